/* logic/dspg_gate.v */
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`include "dspg_defs.vh"
module dspg_gate #(
   parameter PORTS = 8
) (
   input wire clock,
   input wire reset,
   input wire clock_enable,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   input wire sleep_req,
   input wire deep_sleep_req,
   input wire port_access,
   input wire [2:0] port_access_sel,
   output reg port_bus_fault,
   output wire [PORTS-1:0] port_clock_enable,
   output reg irq
);
   // -----------------------------
   // state
   // -----------------------------
   reg [PORTS-1:0] run_gate_reg;
   reg [PORTS-1:0] sleep_gate_reg;
   reg [PORTS-1:0] deep_sleep_gate_reg;
   reg auto_gating_select;
   reg [`DSPG_IRQ_W-1:0] irq_stat_reg;
   reg [`DSPG_IRQ_W-1:0] irq_mask_reg;
   reg [1:0] mode_reg;

   // -----------------------------
   // synchroniser stages
   // -----------------------------
   reg sleep_s1;
   reg sleep_s2;
   reg deep_s1;
   reg deep_s2;
   reg acc_s1;
   reg acc_s2;
   reg acc_d;
   reg [2:0] sel_s1;
   reg [2:0] sel_s2;

   // -----------------------------
   // decode and next-state nets
   // -----------------------------
   reg [PORTS-1:0] enable_target;
   reg [1:0] mode_next;
   reg [31:0] rd_data;
   reg hit;
   wire req;
   wire wr;
   wire wr_cfg;
   wire wr_run;
   wire wr_sleep;
   wire wr_deep;
   wire wr_stat;
   wire wr_mask;
   wire access_edge;
   wire fault_event;
   wire mode_event;
   wire [PORTS-1:0] run_next;
   wire [PORTS-1:0] sleep_next;
   wire [PORTS-1:0] deep_next;
   wire [`DSPG_IRQ_W-1:0] mask_next;
   wire [`DSPG_IRQ_W-1:0] stat_clear;
   wire [`DSPG_IRQ_W-1:0] stat_after;
   wire [`DSPG_IRQ_W-1:0] mask_eff;

   function [PORTS-1:0] merge_bytes;
      input [PORTS-1:0] old_val;
      input [31:0] data;
      input [3:0] sel;
      begin
         merge_bytes = sel[0] ? data[PORTS-1:0] : old_val; // RQ1
      end
   endfunction

   function wr_at;
      input en;
      input [11:0] adr;
      input [11:0] ofs;
      begin
         wr_at = en & (adr == ofs);
      end
   endfunction

   function [PORTS-1:0] pick_gate;
      input auto_sel;
      input [PORTS-1:0] mode_gate;
      input [PORTS-1:0] run_gate;
      begin
         pick_gate = auto_sel ? mode_gate : run_gate;
      end
   endfunction

   // -----------------------------
   // wishbone decode
   // -----------------------------
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign wr = req & wb_we_i & hit;
   assign wr_cfg = wr_at(wr, wb_adr_i, `DSPG_RUN_CFG_OFS);
   assign wr_run = wr_at(wr, wb_adr_i, `DSPG_RUN_GATE_OFS);
   assign wr_sleep = wr_at(wr, wb_adr_i, `DSPG_SLEEP_GATE_OFS);
   assign wr_deep = wr_at(wr, wb_adr_i, `DSPG_DEEP_GATE_OFS); // RQ7
   assign wr_stat = wr_at(wr, wb_adr_i, `DSPG_IRQ_STAT_OFS);
   assign wr_mask = wr_at(wr, wb_adr_i, `DSPG_IRQ_MASK_OFS);
   always @* begin
      hit = 1'b1;
      rd_data = `DSPG_ZERO32; // RQ6
      case (wb_adr_i)
         `DSPG_RUN_CFG_OFS: rd_data[`DSPG_ACG_BIT] = auto_gating_select;
         `DSPG_RUN_GATE_OFS: rd_data[PORTS-1:0] = run_gate_reg; // RQ4
         `DSPG_SLEEP_GATE_OFS: rd_data[PORTS-1:0] = sleep_gate_reg; // RQ4
         `DSPG_DEEP_GATE_OFS: rd_data[PORTS-1:0] = deep_sleep_gate_reg; // RQ7
         `DSPG_IRQ_STAT_OFS: rd_data[`DSPG_IRQ_W-1:0] = irq_stat_reg;
         `DSPG_IRQ_MASK_OFS: rd_data[`DSPG_IRQ_W-1:0] = irq_mask_reg;
         default: hit = 1'b0;
      endcase
   end
   assign run_next = merge_bytes(run_gate_reg, wb_dat_i, wb_sel_i);
   assign sleep_next = merge_bytes(sleep_gate_reg, wb_dat_i, wb_sel_i);
   assign deep_next = merge_bytes(deep_sleep_gate_reg, wb_dat_i, wb_sel_i);
   assign mask_next = wb_sel_i[0] ? wb_dat_i[`DSPG_IRQ_W-1:0] : irq_mask_reg;
   assign stat_clear = (wr_stat && wb_sel_i[0]) ? wb_dat_i[`DSPG_IRQ_W-1:0] :
      {`DSPG_IRQ_W{1'b0}};
   // new mask counts in the same edge, so irq never lags a mask write
   assign mask_eff = wr_mask ? mask_next : irq_mask_reg;
   // set wins over write-one clear
   assign stat_after = (irq_stat_reg & ~stat_clear) | {mode_event, fault_event};

   // -----------------------------
   // mode selection
   // -----------------------------
   always @* begin
      case ({deep_s2, sleep_s2})
         2'b00: mode_next = `DSPG_MODE_RUN;
         2'b01: mode_next = `DSPG_MODE_SLEEP;
         default: mode_next = `DSPG_MODE_DEEP;
      endcase
   end
   always @* begin
      case (mode_reg)
         `DSPG_MODE_SLEEP: enable_target = pick_gate(auto_gating_select, sleep_gate_reg,
            run_gate_reg); // RQ5
         `DSPG_MODE_DEEP: enable_target = pick_gate(auto_gating_select, deep_sleep_gate_reg,
            run_gate_reg); // RQ5
         default: enable_target = run_gate_reg; // RQ4
      endcase
   end
   assign mode_event = (mode_next != mode_reg);

   // -----------------------------
   // port access fault
   // -----------------------------
   assign access_edge = acc_s2 & ~acc_d;
   assign fault_event = access_edge & ~port_clock_enable[sel_s2]; // RQ2

   // -----------------------------
   // pin synchronisers
   // -----------------------------
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         sleep_s1 <= 1'b0;
         sleep_s2 <= 1'b0;
         deep_s1 <= 1'b0;
         deep_s2 <= 1'b0;
         acc_s1 <= 1'b0;
         acc_s2 <= 1'b0;
         acc_d <= 1'b0;
         sel_s1 <= 3'h0;
         sel_s2 <= 3'h0;
      end else if (clock_enable) begin
         sleep_s1 <= sleep_req;
         sleep_s2 <= sleep_s1;
         deep_s1 <= deep_sleep_req;
         deep_s2 <= deep_s1;
         acc_s1 <= port_access;
         acc_s2 <= acc_s1;
         acc_d <= acc_s2;
         sel_s1 <= port_access_sel;
         sel_s2 <= sel_s1;
      end
   end

   // -----------------------------
   // power mode
   // -----------------------------
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         mode_reg <= `DSPG_MODE_RUN;
      end else if (clock_enable) begin
         mode_reg <= mode_next; // RQ8
      end
   end

   // -----------------------------
   // bus response
   // -----------------------------
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         wb_dat_o <= `DSPG_ZERO32;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else if (clock_enable) begin
         wb_ack_o <= req & hit;
         wb_err_o <= req & ~hit;
         wb_dat_o <= (req & hit & ~wb_we_i) ? rd_data : `DSPG_ZERO32;
      end
   end

   // -----------------------------
   // gating and configuration registers
   // -----------------------------
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         auto_gating_select <= `DSPG_CFG_RESET;
      end else if (clock_enable) begin
         if (wr_cfg && wb_sel_i[3]) begin
            auto_gating_select <= wb_dat_i[`DSPG_ACG_BIT]; // RQ5
         end
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         run_gate_reg <= `DSPG_GATE_RESET;
      end else if (clock_enable) begin
         if (wr_run) begin
            run_gate_reg <= run_next; // RQ4
         end
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         sleep_gate_reg <= `DSPG_GATE_RESET;
      end else if (clock_enable) begin
         if (wr_sleep) begin
            sleep_gate_reg <= sleep_next; // RQ4
         end
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         deep_sleep_gate_reg <= `DSPG_GATE_RESET; // RQ3
      end else if (clock_enable) begin
         if (wr_deep) begin
            deep_sleep_gate_reg <= deep_next; // RQ7
         end
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_mask_reg <= {`DSPG_IRQ_W{1'b0}};
      end else if (clock_enable) begin
         if (wr_mask) begin
            irq_mask_reg <= mask_next;
         end
      end
   end

   // -----------------------------
   // interrupts
   // -----------------------------
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_stat_reg <= {`DSPG_IRQ_W{1'b0}};
         irq <= 1'b0;
      end else if (clock_enable) begin
         // irq follows the status value written at this same edge
         irq_stat_reg <= stat_after;
         irq <= |(stat_after & mask_eff);
      end
   end

   // -----------------------------
   // fault output
   // -----------------------------
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         port_bus_fault <= 1'b0;
      end else if (clock_enable) begin
         port_bus_fault <= fault_event; // RQ2
      end
   end

   // -----------------------------
   // enable output stage
   // -----------------------------
   dspg_enable_sync #(
      .PORTS(PORTS)
   ) u_sync (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .enable_target(enable_target),
      .enable_out(port_clock_enable)
   );
endmodule

/* logic/dspg_defs.vh */
// Contract
// RQ1 - one enable bit per port, A..H
// RQ2 - unclocked port access answers bus fault
// RQ3 - deep-sleep gating resets to all zeros
// RQ4 - run, sleep, deep-sleep gating registers
// RQ5 - sleep registers apply only with auto-gating
// RQ6 - bits 31:8 read-only, read zero
// RQ7 - deep-sleep gating decoded at offset 0x128
// RQ8 - glitch-free switch of enables on mode change
`ifndef DSPG_DEFS_VH
`define DSPG_DEFS_VH
`define DSPG_RUN_CFG_OFS 12'h060
`define DSPG_RUN_GATE_OFS 12'h108
`define DSPG_SLEEP_GATE_OFS 12'h118
`define DSPG_DEEP_GATE_OFS 12'h128
`define DSPG_IRQ_STAT_OFS 12'h200
`define DSPG_IRQ_MASK_OFS 12'h204
`define DSPG_ACG_BIT 27
`define DSPG_GATE_RESET 8'h00
`define DSPG_CFG_RESET 1'b0
`define DSPG_ZERO32 32'h00000000
`define DSPG_IRQ_FAULT 0
`define DSPG_IRQ_MODE 1
`define DSPG_IRQ_W 2
`define DSPG_MODE_RUN 2'h0
`define DSPG_MODE_SLEEP 2'h1
`define DSPG_MODE_DEEP 2'h2
`endif

/* logic/dspg_enable_sync.v */
`timescale 1ns/10ps
`include "dspg_defs.vh"
module dspg_enable_sync #(
   parameter PORTS = 8
) (
   input wire clock,
   input wire reset,
   input wire clock_enable,
   input wire [PORTS-1:0] enable_target,
   output reg [PORTS-1:0] enable_out
);
   // -----------------------------
   // enable retiming
   // -----------------------------
   // enables change only on a clock edge or at the asynchronous reset, so a downstream latch gate sees a clean level
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         enable_out <= {PORTS{1'b0}};
      end else if (clock_enable) begin
         enable_out <= enable_target; // RQ8
      end
   end
endmodule

/* testbench/dspg_props.sv */
`timescale 1ns/10ps
module dspg_props #(
   parameter PORTS = 8
) (
   input wire clock,
   input wire reset,
   input wire clock_enable,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [11:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire wb_err_o,
   input wire port_access,
   input wire [2:0] port_access_sel,
   input wire port_bus_fault,
   input wire [PORTS-1:0] port_clock_enable,
   input wire irq
);
   // ----
   // bus and gating checks
   // ----
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && clock_enable;
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_req_answered: assert property (req |=> wb_ack_o || wb_err_o)
      else $error("no answer");
   a_deep_mapped: assert property (req && wb_adr_i == 12'h128 |=> wb_ack_o)
      else $error("gate reg not mapped");
   a_rsvd_zero: assert property (wb_ack_o && $past(wb_adr_i) == 12'h128 |->
      wb_dat_o[31:8] == 24'h000000) else $error("upper bits not zero");
   a_fault_gated: assert property ($rose(port_access) &&
      !port_clock_enable[port_access_sel] |-> ##[1:4] port_bus_fault) else $error("no fault");
   a_open_quiet: assert property ($rose(port_access) &&
      port_clock_enable[port_access_sel] |=> !port_bus_fault [*5]) else $error("bad fault");
   a_no_glitch: assert property ($changed(port_clock_enable) |=>
      $stable(port_clock_enable)) else $error("enable glitch");
   a_reset_gated: assert property ($fell(reset) |-> port_clock_enable == '0)
      else $error("ports clocked after reset");
   c_bus_err: cover property (wb_err_o);
   c_fault: cover property (port_bus_fault);
   c_irq: cover property ($rose(irq));
endmodule
bind dspg_gate dspg_props #(.PORTS(PORTS)) u_props (.clock(clock), .reset(reset),
   .clock_enable(clock_enable), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .irq(irq),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .port_access(port_access), .port_access_sel(port_access_sel),
   .port_bus_fault(port_bus_fault), .port_clock_enable(port_clock_enable));

/* testbench/dspg_port_model.sv */
`timescale 1ns/10ps
module dspg_port_model (
   input wire clock,
   output logic port_access = 1'b0,
   output logic [2:0] port_access_sel = 3'h0
);
   // ----
   // port unit making access attempts
   // ----
   task automatic touch(input logic [2:0] s);
      port_access_sel <= s;
      @(posedge clock);
      port_access <= 1'b1;
      repeat (6) @(posedge clock);
      port_access <= 1'b0;
      port_access_sel <= ~s;
      repeat (6) @(posedge clock);
   endtask
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   // ----
   // register and mode tests
   // ----
   logic clock = 0, reset = 1, cyc = 0, stb = 0, we = 0, sleep = 0, deep = 0, e;
   logic [11:0] adr = 12'h000;
   logic [3:0] be = 4'hf;
   logic ce = 1'b1;
   logic [31:0] wdat = 32'h0, q, nf = 32'h0;
   wire [31:0] rdat;
   wire ack, err, pa, fault, irq;
   wire [2:0] psel;
   wire [7:0] pce;
   int fails = 0, checks = 0, cycles = 0;
   dspg_gate dut (.clock(clock), .reset(reset), .clock_enable(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .sleep_req(sleep),
      .deep_sleep_req(deep), .port_access(pa), .port_access_sel(psel),
      .port_bus_fault(fault), .port_clock_enable(pce), .irq(irq));
   dspg_port_model pm (.clock(clock), .port_access(pa), .port_access_sel(psel));
   initial forever #12.5 clock = ~clock;
   always @(posedge clock) if (fault === 1'b1) nf <= nf + 32'h1;
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x) begin
         $display("BAD %s exp %h got %h", n, x, g);
         fails++;
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clock); while (!(ack | err));
      q = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clock)
      if (++cycles == 4000) begin
         fails++;
         tally_and_finish;
      end
   initial begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      xfer(0, 12'h128, 32'h0);
      chk("deep gate", 32'h0, q);
      chk("enables", 32'h0, {24'h0, pce});
      xfer(1, 12'h128, 32'hffffffff);
      xfer(0, 12'h128, 32'h0);
      chk("deep gate", 32'h000000ff, q);
      xfer(0, 12'h004, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      xfer(1, 12'h108, 32'h0000000f);
      xfer(1, 12'h204, 32'h00000001);
      chk("run enables", 32'hf, {24'h0, pce});
      $display("test regs done");
      deep <= 1'b1;
      repeat (6) @(posedge clock);
      chk("no auto", 32'hf, {24'h0, pce});
      xfer(1, 12'h060, 32'h08000000);
      repeat (2) @(posedge clock);
      chk("deep enables", 32'hff, {24'h0, pce});
      xfer(1, 12'h128, 32'h00000005);
      pm.touch(3'h1);
      chk("fault b", 32'h1, nf);
      pm.touch(3'h2);
      chk("fault c", 32'h1, nf);
      chk("irq", 32'h1, {31'h0, irq});
      xfer(0, 12'h200, 32'h0);
      chk("irq status", 32'h3, q);
      xfer(0, 12'h204, 32'h0);
      chk("irq mask", 32'h1, q);
      xfer(1, 12'h200, 32'h00000003);
      chk("irq clear", 32'h0, {31'h0, irq});
      xfer(0, 12'h200, 32'h0);
      chk("status clear", 32'h0, q);
      $display("test deep done");
      be <= 4'h6;
      xfer(1, 12'h118, 32'h000000ff);
      xfer(1, 12'h060, 32'h00000000);
      be <= 4'hf;
      xfer(0, 12'h118, 32'h0);
      chk("sel gate", 32'h0, q);
      xfer(0, 12'h060, 32'h0);
      chk("sel cfg", 32'h08000000, q);
      xfer(1, 12'h118, 32'h00000030);
      sleep <= 1'b1;
      @(posedge clock);
      deep <= 1'b0;
      repeat (6) @(posedge clock);
      chk("sleep enables", 32'h30, {24'h0, pce});
      sleep <= 1'b0;
      repeat (6) @(posedge clock);
      chk("wake enables", 32'hf, {24'h0, pce});
      ce <= 1'b0;
      sleep <= 1'b1;
      repeat (6) @(posedge clock);
      chk("frozen enables", 32'hf, {24'h0, pce});
      ce <= 1'b1;
      repeat (6) @(posedge clock);
      chk("thawed enables", 32'h30, {24'h0, pce});
      sleep <= 1'b0;
      repeat (6) @(posedge clock);
      $display("test modes done");
      reset <= 1'b1;
      @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      chk("reset enables", 32'h0, {24'h0, pce});
      xfer(0, 12'h128, 32'h0);
      chk("reset deep gate", 32'h0, q);
      $display("test reset done");
      tally_and_finish;
   end
endmodule
